//--- design/bep_pkg.sv
// Shared constants for the burst memory programming/identifier link.
// Assumes one core clock at 100 MHz shared by both ends.
package bep_pkg;
  localparam int unsigned ADDR_W        = 17;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned BLOCK_W       = 15;
  localparam int unsigned SEL_W         = 2;
  localparam int unsigned MEM_DEPTH     = 256;
  localparam int unsigned MEM_AW        = 8;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  // Identifier bytes: values are arbitrary, not any real maker or part
  localparam logic [DATA_W-1:0] ID_MAKER    = 8'h5A;
  localparam logic [DATA_W-1:0] ID_PART     = 8'h3C;
  localparam logic [DATA_W-1:0] ID_VARIANT  = 8'h02;
  localparam logic [DATA_W-1:0] WS_CODE_ONE = 8'h03;
  localparam logic [DATA_W-1:0] WS_CODE_TWO = 8'h02;
  localparam logic [SEL_W-1:0]  ID_SEL_MAKER   = 2'h0;
  localparam logic [SEL_W-1:0]  ID_SEL_PART    = 2'h1;
  localparam logic [SEL_W-1:0]  ID_SEL_VARIANT = 2'h2;
  localparam logic [SEL_W-1:0]  ID_SEL_WAIT    = 2'h3;
  localparam logic [SEL_W-1:0]  SEL_STEP       = 2'h1;
  // Reset timing in clock cycles
  localparam int unsigned RST_HOLD_CYC  = 10;
  localparam int unsigned RST_SETTLE_CYC = 5;
  localparam int unsigned CNT_W         = 4;
  localparam logic [CNT_W-1:0] RST_HOLD_CNT   = CNT_W'(RST_HOLD_CYC);
  localparam logic [CNT_W-1:0] RST_SETTLE_CNT = CNT_W'(RST_SETTLE_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE        = 4'h1;
  // Programming algorithm
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned PULSE_US      = 100;
  localparam int unsigned PULSE_CYC     = PULSE_US * CLK_MHZ;
  localparam int unsigned PULSE_W       = 14;
  // Pulse count at which the device's verify byte stands on the bus
  localparam logic [PULSE_W-1:0] VERIFY_AT = 14'h0002;
  localparam int unsigned MAX_PULSES    = 25;
  localparam int unsigned TRY_W         = 5;
  localparam logic [TRY_W-1:0] MAX_PULSES_CNT = TRY_W'(MAX_PULSES);
  localparam logic [TRY_W-1:0] TRY_ONE        = 5'h01;
endpackage

//--- design/bep_if.sv
// Pin-level link between the memory device and its programmer/host.
// Data bus is two-way; the testbench resolves its level from the enables.
`timescale 1ns/1ps
`default_nettype none
interface bep_if;
  logic                          chip_select_n;
  logic                          address_strobe_n;
  logic                          burst_final_n;
  logic                          program_pulse_n;
  logic                          identifier_entry_level;
  logic                          prog_supply_high;
  logic [bep_pkg::BLOCK_W-1:0]   block_address_bits;
  logic [bep_pkg::SEL_W-1:0]     byte_select_bits;
  logic [bep_pkg::DATA_W-1:0]    host_data;
  logic                          host_data_oe;
  logic [bep_pkg::DATA_W-1:0]    dev_data;
  logic                          dev_data_oe;
  logic [bep_pkg::DATA_W-1:0]    data_in;
  modport device (
    input  chip_select_n, address_strobe_n, burst_final_n, program_pulse_n,
    input  identifier_entry_level, prog_supply_high, block_address_bits,
    input  byte_select_bits, data_in,
    output dev_data, dev_data_oe
  );
  modport host (
    output chip_select_n, address_strobe_n, burst_final_n, program_pulse_n,
    output identifier_entry_level, prog_supply_high, block_address_bits,
    output byte_select_bits, host_data, host_data_oe,
    input  data_in
  );
endinterface
`default_nettype wire

//--- design/bep_device.sv
// Device end: program/verify, program inhibit, identifier burst, reset.
// Assumes the link's inputs are synchronous to core_clk_i (shared clock).
`timescale 1ns/1ps
`default_nettype none
module bep_device #(
  parameter bit TWO_WAIT = 1'b1
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        arst_n_i,
  bep_if.device                            link,
  output logic                             ready_o,
  output logic                             busy_o
);
  typedef enum logic [2:0] {
    ST_SETTLE, ST_IDLE, ST_PROG, ST_VERIFY, ST_END, ST_ID_WAIT, ST_ID_DATA
  } dev_state_t;

  dev_state_t                     state_q;
  logic [bep_pkg::DATA_W-1:0]     mem_q [bep_pkg::MEM_DEPTH];
  logic [bep_pkg::ADDR_W-1:0]     addr_q;
  logic [bep_pkg::SEL_W-1:0]      sel_q;
  logic [bep_pkg::DATA_W-1:0]     dout_q;
  logic                           doe_q;
  logic [bep_pkg::CNT_W-1:0]      settle_q;
  logic                           start;

  function automatic logic [bep_pkg::DATA_W-1:0] id_byte(
    input logic [bep_pkg::SEL_W-1:0] sel
  );
    unique case (sel)
      bep_pkg::ID_SEL_MAKER:   id_byte = bep_pkg::ID_MAKER;
      bep_pkg::ID_SEL_PART:    id_byte = bep_pkg::ID_PART;
      bep_pkg::ID_SEL_VARIANT: id_byte = bep_pkg::ID_VARIANT;
      default:                 id_byte = TWO_WAIT ? bep_pkg::WS_CODE_TWO
                                                  : bep_pkg::WS_CODE_ONE;
    endcase
  endfunction

  // Strobe only counts in idle; later strobes are dropped
  assign start = (state_q == ST_IDLE) && !link.address_strobe_n
                 && !link.chip_select_n;

  // Settle counter after reset release
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      settle_q <= '0;
    else if (settle_q != bep_pkg::RST_SETTLE_CNT)
      settle_q <= settle_q + bep_pkg::CNT_ONE;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_q <= ST_SETTLE;
    else
    begin
      unique case (state_q)
        ST_SETTLE:
          if (settle_q == bep_pkg::RST_SETTLE_CNT)
            state_q <= ST_IDLE;
        ST_IDLE:
          if (start)
          begin
            if (link.identifier_entry_level)
              state_q <= ST_ID_WAIT;
            else if (link.prog_supply_high)
              state_q <= ST_PROG;
          end
        ST_PROG:    state_q <= ST_VERIFY;
        ST_VERIFY:  state_q <= ST_END;
        ST_END:     state_q <= ST_IDLE;
        ST_ID_WAIT:
          if (!link.burst_final_n)
            state_q <= ST_IDLE;
          else
            state_q <= ST_ID_DATA;
        ST_ID_DATA:
          if (!link.burst_final_n)
            state_q <= ST_IDLE;
      endcase
    end
  end

  // Address capture; byte select never auto-increments while programming
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      addr_q <= '0;
      sel_q  <= '0;
    end
    else if (start)
    begin
      addr_q <= {link.block_address_bits, link.byte_select_bits};
      sel_q  <= link.byte_select_bits;
    end
    else if (state_q == ST_ID_DATA)
      sel_q <= sel_q + bep_pkg::SEL_STEP;
  end

  // Array: erased state is all ones, programming only ANDs in zeros
  always_ff @(posedge core_clk_i)
  begin
    if (state_q == ST_PROG && !link.program_pulse_n && !link.chip_select_n)
      mem_q[addr_q[bep_pkg::MEM_AW-1:0]] <=
        mem_q[addr_q[bep_pkg::MEM_AW-1:0]] & link.data_in;
  end

  // Models the erased array at power-up; only UV restores ones
  initial
  begin
    for (int i = 0; i < bep_pkg::MEM_DEPTH; i++)
      mem_q[i] = bep_pkg::ERASED_BYTE;
  end

  // Output drive: verify byte in cycle two, identifier bytes in burst
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      doe_q  <= 1'b0;
      dout_q <= '0;
    end
    else if (state_q == ST_PROG)
    begin
      doe_q  <= !link.chip_select_n;
      dout_q <= mem_q[addr_q[bep_pkg::MEM_AW-1:0]] &
                (link.program_pulse_n ? bep_pkg::ERASED_BYTE : link.data_in);
    end
    else if ((state_q == ST_ID_WAIT || state_q == ST_ID_DATA) && link.burst_final_n)
    begin
      doe_q  <= 1'b1;
      dout_q <= id_byte(state_q == ST_ID_WAIT ? sel_q : sel_q + bep_pkg::SEL_STEP);
    end
    else
      doe_q <= 1'b0;
  end

  // Asynchronous float during reset
  always_comb
  begin
    link.dev_data    = dout_q;
    link.dev_data_oe = doe_q & arst_n_i;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ready_o <= 1'b0;
      busy_o  <= 1'b0;
    end
    else
    begin
      ready_o <= (state_q == ST_IDLE);
      busy_o  <= (state_q != ST_IDLE) && (state_q != ST_SETTLE);
    end
  end
endmodule // bep_device
`default_nettype wire

//--- design/bep_host.sv
// Programmer end: runs pulse/verify loop, identifier read, device reset.
// Assumes the device shares core_clk_i; drives device reset as a port.
`timescale 1ns/1ps
`default_nettype none
module bep_host #(
  parameter int unsigned PULSE_CYC = bep_pkg::PULSE_CYC
) (
  input  wire logic                         core_clk_i,
  input  wire logic                         arst_n_i,
  bep_if.host                               link,
  input  wire logic                         prog_req_i,
  input  wire logic                         id_req_i,
  input  wire logic [bep_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [bep_pkg::DATA_W-1:0]   data_i,
  output logic                              dev_rst_n_o,
  output logic                              done_o,
  output logic                              fail_o,
  output logic [bep_pkg::DATA_W-1:0]        rdata_o,
  output logic                              rvalid_o
);
  typedef enum logic [3:0] {
    H_RST, H_SETTLE, H_IDLE, H_STROBE, H_PULSE, H_VERIFY, H_END, H_ID_STROBE,
    H_ID_WAIT, H_ID_DATA
  } host_state_t;

  host_state_t                   st_q;
  logic [bep_pkg::CNT_W-1:0]     cnt_q;
  logic [bep_pkg::PULSE_W-1:0]   pcnt_q;
  logic [bep_pkg::TRY_W-1:0]     tries_q;
  logic [bep_pkg::ADDR_W-1:0]    addr_q;
  logic [bep_pkg::DATA_W-1:0]    data_q;
  logic [bep_pkg::SEL_W-1:0]     idn_q;
  logic                          id_mode_q;
  logic [bep_pkg::DATA_W-1:0]    vbyte_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q <= H_RST;
      cnt_q <= '0;
      pcnt_q <= '0;
      tries_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      idn_q <= '0;
      id_mode_q <= 1'b0;
      vbyte_q <= '0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      rdata_o <= '0;
      rvalid_o <= 1'b0;
      dev_rst_n_o <= 1'b0;
      link.chip_select_n <= 1'b1;
      link.address_strobe_n <= 1'b1;
      link.burst_final_n <= 1'b1;
      link.program_pulse_n <= 1'b1;
      link.identifier_entry_level <= 1'b0;
      link.prog_supply_high <= 1'b0;
      link.block_address_bits <= '0;
      link.byte_select_bits <= '0;
      link.host_data <= '0;
      link.host_data_oe <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      rvalid_o <= 1'b0;
      link.address_strobe_n <= 1'b1; // single-cycle strobe
      link.burst_final_n <= 1'b1;
      unique case (st_q)
        H_RST:
        begin
          cnt_q <= cnt_q + bep_pkg::CNT_ONE;
          if (cnt_q == bep_pkg::RST_HOLD_CNT)
          begin
            dev_rst_n_o <= 1'b1;
            cnt_q <= '0;
            st_q <= H_SETTLE;
          end
        end
        H_SETTLE:
        begin
          cnt_q <= cnt_q + bep_pkg::CNT_ONE;
          if (cnt_q == bep_pkg::RST_SETTLE_CNT)
            st_q <= H_IDLE;
        end
        H_IDLE:
        begin
          link.chip_select_n <= 1'b1;
          link.identifier_entry_level <= 1'b0;
          if (prog_req_i)
          begin
            addr_q <= addr_i;
            data_q <= data_i;
            tries_q <= '0;
            fail_o <= 1'b0;
            st_q <= H_STROBE;
          end
          else if (id_req_i)
            st_q <= H_ID_STROBE;
        end
        H_STROBE:
        begin
          link.prog_supply_high <= 1'b1;
          link.chip_select_n <= 1'b0;
          link.address_strobe_n <= 1'b0;
          link.block_address_bits <= addr_q[bep_pkg::ADDR_W-1:bep_pkg::SEL_W];
          link.byte_select_bits <= addr_q[bep_pkg::SEL_W-1:0];
          link.host_data <= data_q;
          link.host_data_oe <= 1'b1;
          pcnt_q <= '0;
          st_q <= H_PULSE;
        end
        H_PULSE:
        begin
          // Device sits in its program cycle; the pulse spans the edge
          link.program_pulse_n <= 1'b0;
          pcnt_q <= pcnt_q + 1'b1;
          // Verify byte stands only one cycle, long before the pulse ends
          if (pcnt_q == bep_pkg::VERIFY_AT)
            vbyte_q <= link.data_in;
          if (pcnt_q == bep_pkg::PULSE_W'(PULSE_CYC - 1))
          begin
            link.program_pulse_n <= 1'b1;
            link.host_data_oe <= 1'b0;
            tries_q <= tries_q + bep_pkg::TRY_ONE;
            st_q <= H_VERIFY;
          end
        end
        H_VERIFY: st_q <= H_END;
        H_END:
        begin
          link.chip_select_n <= 1'b1;
          rdata_o <= vbyte_q;
          rvalid_o <= 1'b1;
          if (vbyte_q == data_q)
          begin
            done_o <= 1'b1;
            link.prog_supply_high <= 1'b0;
            st_q <= H_IDLE;
          end
          else if (tries_q == bep_pkg::MAX_PULSES_CNT)
          begin
            fail_o <= 1'b1;
            done_o <= 1'b1;
            link.prog_supply_high <= 1'b0;
            st_q <= H_IDLE;
          end
          else
            st_q <= H_STROBE;
        end
        H_ID_STROBE:
        begin
          id_mode_q <= 1'b1;
          link.identifier_entry_level <= 1'b1;
          link.chip_select_n <= 1'b0;
          link.address_strobe_n <= 1'b0;
          link.block_address_bits <= '0;
          link.byte_select_bits <= bep_pkg::ID_SEL_MAKER;
          idn_q <= '0;
          cnt_q <= '0;
          st_q <= H_ID_WAIT;
        end
        H_ID_WAIT:
        begin
          // Device's first byte appears one edge after its wait state
          cnt_q <= cnt_q + bep_pkg::CNT_ONE;
          if (cnt_q == bep_pkg::CNT_ONE)
            st_q <= H_ID_DATA;
        end
        H_ID_DATA:
        begin
          link.chip_select_n <= 1'b1;
          rdata_o <= link.data_in;
          rvalid_o <= 1'b1;
          idn_q <= idn_q + bep_pkg::SEL_STEP;
          if (idn_q == bep_pkg::ID_SEL_VARIANT)
            link.burst_final_n <= 1'b0; // by fourth byte
          if (idn_q == bep_pkg::ID_SEL_WAIT)
          begin
            id_mode_q <= 1'b0;
            done_o <= 1'b1;
            st_q <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule // bep_host
`default_nettype wire

//--- bench/bep_assertions.sv
// Checker for the device end of the programming/identifier link.
// Assumes one clock; arst_n_i is the device's own reset.
`timescale 1ns/1ps
`default_nettype none
module bep_assertions #(
  parameter bit TWO_WAIT = 1'b1
) (
  input wire logic                       core_clk_i,
  input wire logic                       arst_n_i,
  input wire logic                       chip_select_n,
  input wire logic                       address_strobe_n,
  input wire logic                       burst_final_n,
  input wire logic                       identifier_entry_level,
  input wire logic                       prog_supply_high,
  input wire logic [bep_pkg::SEL_W-1:0]  byte_select_bits,
  input wire logic [bep_pkg::DATA_W-1:0] dev_data,
  input wire logic                       dev_data_oe
);
  // Shadow of the device state, rebuilt from the pins alone
  logic [2:0]                 settle_q;
  logic [2:0]                 mode_q;
  logic [1:0]                 idx_q;
  logic                       take;
  logic [bep_pkg::DATA_W-1:0] id_exp;
  assign take = (mode_q == 3'h0) && (settle_q == 3'h6) && !address_strobe_n && !chip_select_n;
  assign id_exp = (idx_q == 2'h0) ? bep_pkg::ID_MAKER : (idx_q == 2'h1) ? bep_pkg::ID_PART :
                  (idx_q == 2'h2) ? bep_pkg::ID_VARIANT :
                  TWO_WAIT ? bep_pkg::WS_CODE_TWO : bep_pkg::WS_CODE_ONE;
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      settle_q <= 3'h0;
    else if (settle_q != 3'h6)
      settle_q <= settle_q + 3'h1;
  end
  // Program walks 1..3 then idle; 4 is an identifier burst
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mode_q <= 3'h0;
    else if (take)
      mode_q <= identifier_entry_level ? 3'h4 : {2'h0, prog_supply_high};
    else if (mode_q == 3'h4)
      mode_q <= (dev_data_oe && !burst_final_n) ? 3'h0 : 3'h4;
    else if (mode_q != 3'h0)
      mode_q <= (mode_q == 3'h3) ? 3'h0 : mode_q + 3'h1;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      idx_q <= 2'h0;
    else if (take)
      idx_q <= byte_select_bits;
    else if (mode_q == 3'h4 && dev_data_oe)
      idx_q <= idx_q + 2'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_reset_float; disable iff (1'b0) !arst_n_i |-> !dev_data_oe; endproperty
  a_reset_float: assert property (p_reset_float) else $error("data in reset");
  property p_prog_seq; take && !identifier_entry_level && prog_supply_high
    |=> !dev_data_oe ##1 dev_data_oe ##1 !dev_data_oe [*2]; endproperty
  a_prog_seq: assert property (p_prog_seq) else $error("bad program walk");
  property p_id_wait; take && identifier_entry_level |=> !dev_data_oe ##1 dev_data_oe; endproperty
  a_id_wait: assert property (p_id_wait) else $error("id first byte late");
  property p_id_stand; mode_q == 3'h4 && dev_data_oe && burst_final_n |=> dev_data_oe; endproperty
  a_id_stand: assert property (p_id_stand) else $error("id burst cut short");
  property p_id_end; mode_q == 3'h4 && dev_data_oe && !burst_final_n |=> !dev_data_oe; endproperty
  a_id_end: assert property (p_id_end) else $error("id burst not ended");
  property p_id_data; mode_q == 3'h4 && dev_data_oe |-> dev_data == id_exp; endproperty
  a_id_data: assert property (p_id_data) else $error("wrong id byte");
  property p_idle_quiet; mode_q == 3'h0 && settle_q == 3'h6 |-> !dev_data_oe; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("data when idle");
  property p_settle_quiet; settle_q != 3'h6 |-> !dev_data_oe; endproperty
  a_settle_quiet: assert property (p_settle_quiet) else $error("early data");
endmodule // bep_assertions
`default_nettype wire

//--- bench/tb.sv
// Testbench: host and device on one link, a second device driven by hand.
// Assumes a 100 MHz clock and the package identifier values.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk;
  logic       rst_n;
  logic       rst_b_n;
  logic       dev_rst_n;
  logic       id_req;
  logic       prog_req;
  logic       done;
  logic       rvalid;
  logic [7:0] rdata;
  logic [7:0] tick_q;
  logic       busy_b;
  logic       ready_b;
  logic       fail;
  int         err_total;
  int         compares;
  bep_if link ();
  bep_if link_b ();
  // Released data lines show a moving pattern, never the last value
  assign link.data_in = link.dev_data_oe ? link.dev_data :
                        link.host_data_oe ? link.host_data : tick_q;
  assign link_b.data_in = link_b.dev_data_oe ? link_b.dev_data :
                          link_b.host_data_oe ? link_b.host_data : tick_q;
  bep_host #(.PULSE_CYC(4)) u_bep_host (.core_clk_i(clk), .arst_n_i(rst_n), .link(link),
    .prog_req_i(prog_req), .id_req_i(id_req), .addr_i(17'h00012), .data_i(8'h5A),
    .dev_rst_n_o(dev_rst_n), .done_o(done), .fail_o(fail), .rdata_o(rdata), .rvalid_o(rvalid));
  bep_device u_bep_device (.core_clk_i(clk), .arst_n_i(dev_rst_n), .link(link),
    .ready_o(), .busy_o());
  // Hand-driven one-wait part reaches pulse timing the host never makes
  bep_device #(.TWO_WAIT(1'b0)) u_bep_device_b (.core_clk_i(clk), .arst_n_i(rst_b_n),
    .link(link_b), .ready_o(ready_b), .busy_o(busy_b));
  bep_assertions #(.TWO_WAIT(1'b1)) u_bep_assertions (.core_clk_i(clk), .arst_n_i(dev_rst_n),
    .chip_select_n(link.chip_select_n), .address_strobe_n(link.address_strobe_n),
    .burst_final_n(link.burst_final_n), .identifier_entry_level(link.identifier_entry_level),
    .prog_supply_high(link.prog_supply_high), .byte_select_bits(link.byte_select_bits),
    .dev_data(link.dev_data), .dev_data_oe(link.dev_data_oe));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tick_q <= tick_q + 8'h01;
  task automatic close_out();
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] id_exp(input logic [1:0] i, input logic two);
    case (i)
      2'h0: return bep_pkg::ID_MAKER;
      2'h1: return bep_pkg::ID_PART;
      2'h2: return bep_pkg::ID_VARIANT;
      default: return two ? bep_pkg::WS_CODE_TWO : bep_pkg::WS_CODE_ONE;
    endcase
  endfunction
  task automatic host_id();
    int k;
    int n;
    n = 0;
    id_req = 1'b1;
    for (k = 0; k < 200 && n < 4; k++)
    begin
      @(negedge clk);
      id_req = 1'b0;
      if (rvalid === 1'b1)
      begin
        chk8(rdata, id_exp(n[1:0], 1'b1));
        n++;
      end
    end
    chk1(n == 4, 1'b1);
    if (n != 4)
      close_out();
  endtask
  task automatic host_prog();
    int k;
    // Step past any done pulse left standing by the previous operation
    prog_req = 1'b1;
    @(negedge clk);
    prog_req = 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++)
      @(negedge clk);
    chk1(done, 1'b1);
    chk1(fail, 1'b0);
    chk8(rdata, 8'h5A);
    if (done !== 1'b1)
      close_out();
  endtask
  // Called on a falling edge; leaves on one, so calls can run back to back
  task automatic b_prog(input logic [7:0] a, input logic [7:0] d, input logic cs_n,
                        input logic pulse_n, input logic again, input logic [7:0] exp);
    link_b.address_strobe_n = 1'b0;
    link_b.chip_select_n = cs_n;
    link_b.block_address_bits = {9'h000, a[7:2]};
    link_b.byte_select_bits = a[1:0];
    link_b.host_data = d;
    link_b.host_data_oe = 1'b1;
    link_b.program_pulse_n = pulse_n;
    @(negedge clk);
    link_b.address_strobe_n = 1'b1;
    @(negedge clk);
    link_b.address_strobe_n = !again;
    link_b.program_pulse_n = 1'b1;
    link_b.host_data_oe = 1'b0;
    chk1(link_b.dev_data_oe, !cs_n);
    chk1(busy_b, !cs_n);
    if (!cs_n)
      chk8(link_b.data_in, exp);
    @(negedge clk);
    link_b.address_strobe_n = 1'b1;
    chk1(link_b.dev_data_oe, 1'b0);
    @(negedge clk);
    chk1(link_b.dev_data_oe, 1'b0);
  endtask
  task automatic b_id(input logic [1:0] s, input int n);
    int i;
    link_b.identifier_entry_level = 1'b1;
    link_b.address_strobe_n = 1'b0;
    link_b.chip_select_n = 1'b0;
    link_b.byte_select_bits = s;
    @(negedge clk);
    link_b.address_strobe_n = 1'b1;
    for (i = 0; i < n; i++)
    begin
      @(negedge clk);
      chk1(link_b.dev_data_oe, 1'b1);
      chk8(link_b.data_in, id_exp(s + i[1:0], 1'b0));
      link_b.burst_final_n = (i != n - 1);
    end
    @(negedge clk);
    link_b.burst_final_n = 1'b1;
    chk1(link_b.dev_data_oe, 1'b0);
  endtask
  task automatic b_reset();
    int i;
    link_b.address_strobe_n = 1'b0;
    @(negedge clk);
    link_b.address_strobe_n = 1'b1;
    @(negedge clk);
    #2 rst_b_n = 1'b0;
    #1 chk1(link_b.dev_data_oe, 1'b0);
    repeat (10) @(negedge clk);
    rst_b_n = 1'b1;
    @(negedge clk);
    link_b.address_strobe_n = 1'b0;
    @(negedge clk);
    link_b.address_strobe_n = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      @(negedge clk);
      chk1(link_b.dev_data_oe, 1'b0);
    end
    link_b.identifier_entry_level = 1'b0;
    repeat (4) @(negedge clk);
    chk1(ready_b, 1'b1);
  endtask
  initial
  begin
    err_total = 0;
    compares = 0;
    tick_q = 8'h00;
    rst_n = 1'b0;
    rst_b_n = 1'b0;
    id_req = 1'b0;
    prog_req = 1'b0;
    link_b.chip_select_n = 1'b1;
    link_b.address_strobe_n = 1'b1;
    link_b.burst_final_n = 1'b1;
    link_b.program_pulse_n = 1'b1;
    link_b.identifier_entry_level = 1'b0;
    link_b.prog_supply_high = 1'b1;
    link_b.block_address_bits = '0;
    link_b.byte_select_bits = 2'h0;
    link_b.host_data = 8'h00;
    link_b.host_data_oe = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rst_b_n = 1'b1;
    repeat (40) @(negedge clk);
    host_id();
    host_prog();
    b_prog(8'h21, 8'hF0, 1'b0, 1'b0, 1'b0, 8'hF0);
    b_prog(8'h21, 8'h3C, 1'b0, 1'b0, 1'b1, 8'h30);
    b_prog(8'h21, 8'hFF, 1'b0, 1'b0, 1'b0, 8'h30);
    b_prog(8'h21, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00);
    b_prog(8'h21, 8'hFF, 1'b0, 1'b0, 1'b0, 8'h30);
    b_prog(8'h22, 8'h00, 1'b0, 1'b1, 1'b0, 8'hFF);
    b_prog(8'h20, 8'hFF, 1'b0, 1'b0, 1'b0, 8'hFF);
    b_id(2'h0, 4);
    b_id(2'h2, 4);
    b_id(2'h3, 1);
    b_reset();
    b_prog(8'h21, 8'hFF, 1'b0, 1'b0, 1'b0, 8'h30);
    close_out();
  end
endmodule // tb
`default_nettype wire
